// [pkg/dind_consts.svh]
`ifndef DIND_CONSTS_SVH
`define DIND_CONSTS_SVH
// Notes on behaviour
// - buffered sense-low voltage watched by default; bypass bit selects drive terminal instead.
// - comparator sampled by an internal strobe of about 800 ns period.
// - five-bit debounce code; code zero bypasses debouncing entirely.
// - codes 01 to 1f map to fixed intervals from 0.0130 ms to 75 ms.
// - one mode bit selects counting mode 0 or 1; mode 0 after reset.
// - mode 0: new-level samples count up, old-level samples count down.
// - mode 0: output takes comparator state at target; reverting reverses direction.
// - mode 1: count each new-level sample; at target toggle output, clear counter.
// - mode 1: counter clears at once when a sample matches output again.
// - result reaches status and pin a debounced, passed through, or inverted.
// - pin a drives debounced comparator only when its setup selects that.
// - threshold reference selectable between fixed voltage and supply-proportional value.
// - loop-powered mode: converter measures field terminals over 0 to 12 v.
// - invert bit inverts debounced signal before comparator status.

`define DIND_CLK_MHZ        250
`define DIND_SAMPLE_NS      800
`define DIND_SAMPLE_CYC     ((`DIND_SAMPLE_NS * `DIND_CLK_MHZ) / 1000)

`define DIND_REG_FILTER     32'h0000_0000
`define DIND_REG_THRESH     32'h0000_0004
`define DIND_REG_PIN        32'h0000_0008
`define DIND_REG_STATUS     32'h0000_000c

// filter config fields
`define DIND_F_TIME_LSB     0
`define DIND_F_MODE         5
`define DIND_F_INV          6
// threshold config fields
`define DIND_T_BYPASS       0
`define DIND_T_REFMODE      1
`define DIND_T_LOOP         2
// pin setup: function code for debounced output
`define DIND_PIN_FUNC_DIN   3'h3

`define DIND_FILTER_RST     7'h00
`define DIND_THRESH_RST     3'h0
`define DIND_PIN_RST        3'h0
`endif

// [pkg/dind_pkg.sv]
package dind_pkg;
	typedef logic [4:0] dind_code_t;
	typedef logic [16:0] dind_cnt_t;
	typedef enum logic [1:0] {
		DIND_IDLE  = 2'b00,
		DIND_COUNT = 2'b01
	} dind_state_e;
endpackage

// [design/dind_sampler.sv]
`include "dind_consts.svh"
module dind_sampler (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic comp_in,
	output logic      sample_stb,
	output logic      sample_val
);
	import dind_pkg::*;
	localparam int unsigned PER = `DIND_SAMPLE_CYC;
	logic [7:0] div;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div <= 8'h00;
		end else if (div == 8'(PER - 1)) begin
			div <= 8'h00;
		end else begin
			div <= div + 8'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sample_stb <= 1'b0;
			sample_val <= 1'b0;
		end else begin
			sample_stb <= (div == 8'(PER - 1));
			if (div == 8'(PER - 1)) begin
				sample_val <= comp_in;
			end
		end
	end

	chk_strobe_period: assert property (@(posedge clock) disable iff (!rst_n)
		sample_stb |=> !sample_stb [*8]) else $error("sample strobe too frequent");
endmodule // dind_sampler

// [design/dind_target_rom.sv]
`include "dind_consts.svh"
module dind_target_rom (
	input  wire logic            [4:0]  code,
	output logic                 [16:0] target
);
	import dind_pkg::*;
	// interval in tenths of a microsecond, divided by 0.8 us sample period
	function automatic logic [16:0] tgt(input logic [4:0] c);
		logic [19:0] t;
		t = 20'h0;
		case (c)
			5'h01: t = 20'd130;    5'h02: t = 20'd187;    5'h03: t = 20'd244;
			5'h04: t = 20'd325;    5'h05: t = 20'd423;    5'h06: t = 20'd561;
			5'h07: t = 20'd756;    5'h08: t = 20'd1008;   5'h09: t = 20'd1301;
			5'h0a: t = 20'd1805;   5'h0b: t = 20'd2406;   5'h0c: t = 20'd3203;
			5'h0d: t = 20'd4203;   5'h0e: t = 20'd5602;   5'h0f: t = 20'd7504;
			5'h10: t = 20'd10008;  5'h11: t = 20'd13008;  5'h12: t = 20'd18008;
			5'h13: t = 20'd24008;  5'h14: t = 20'd32008;  5'h15: t = 20'd42008;
			5'h16: t = 20'd56008;  5'h17: t = 20'd75007;  5'h18: t = 20'd100007;
			5'h19: t = 20'd130007; 5'h1a: t = 20'd180006; 5'h1b: t = 20'd240006;
			5'h1c: t = 20'd320005; 5'h1d: t = 20'd420004; 5'h1e: t = 20'd560003;
			5'h1f: t = 20'd750000;
			default: t = 20'h0;
		endcase
		return 17'((t + 20'd4) / 20'd8); // rounded to whole samples
	endfunction
	assign target = tgt(code);
endmodule // dind_target_rom

// [design/dind_top.sv]
`include "dind_consts.svh"
module dind_top (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	input  wire logic        comp_sense_low_terminal,
	input  wire logic        comp_drive_terminal,
	output logic             input_buffer_bypass,
	output logic             thresh_ref_supply,
	output logic             loop_adc_field_range,
	output logic             aux_pin_a_out,
	output logic             aux_pin_a_oe
);
	import dind_pkg::*;

	logic [6:0]  input_filter_config;
	logic [2:0]  input_threshold_config;
	logic [2:0]  aux_pin_setup;
	logic        comp_raw;
	logic        smp_stb;
	logic        smp_val;
	logic [16:0] target;
	dind_cnt_t   cnt;
	logic        deb;
	logic        up_dir;
	logic        cfg_chg;
	logic [5:0]  cfg_prev;
	logic        comparator_invert;
	logic        mode1;
	dind_code_t  code;
	logic        filtered;
	logic        status_bit;
	logic        bus_req;

	assign code              = input_filter_config[`DIND_F_TIME_LSB +: 5];
	assign mode1             = input_filter_config[`DIND_F_MODE];
	assign comparator_invert = input_filter_config[`DIND_F_INV];

	// source select
	assign comp_raw = input_threshold_config[`DIND_T_BYPASS] ? comp_drive_terminal
		: comp_sense_low_terminal;

	dind_sampler u_smp (
		.clock      (clock),
		.rst_n      (rst_n),
		.comp_in    (comp_raw),
		.sample_stb (smp_stb),
		.sample_val (smp_val)
	);

	dind_target_rom u_rom (
		.code   (code),
		.target (target)
	);

	// bus slave: one wait state free, ack one cycle after request
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			input_filter_config    <= `DIND_FILTER_RST;
			input_threshold_config <= `DIND_THRESH_RST;
			aux_pin_setup          <= `DIND_PIN_RST;
		end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				`DIND_REG_FILTER: input_filter_config    <= wb_dat_i[6:0];
				`DIND_REG_THRESH: input_threshold_config <= wb_dat_i[2:0];
				`DIND_REG_PIN:    aux_pin_setup          <= wb_dat_i[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`DIND_REG_FILTER: wb_dat_o <= {25'h0, input_filter_config};
				`DIND_REG_THRESH: wb_dat_o <= {29'h0, input_threshold_config};
				`DIND_REG_PIN:    wb_dat_o <= {29'h0, aux_pin_setup};
				`DIND_REG_STATUS: wb_dat_o <= {31'h0, status_bit};
				default:          wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	assign input_buffer_bypass  = input_threshold_config[`DIND_T_BYPASS];
	assign thresh_ref_supply    = input_threshold_config[`DIND_T_REFMODE];
	assign loop_adc_field_range = input_threshold_config[`DIND_T_LOOP];

	// config change detect
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_prev <= 6'h00;
		end else begin
			cfg_prev <= input_filter_config[5:0];
		end
	end
	assign cfg_chg = (cfg_prev != input_filter_config[5:0]);

	assign up_dir = (smp_val != deb);

	// debounce counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 17'h00000;
		end else if (cfg_chg || code == 5'h00) begin
			cnt <= 17'h00000;
		end else if (smp_stb) begin
			if (!mode1) begin
				if (up_dir) begin
					if (cnt + 17'h00001 >= target) begin
						cnt <= 17'h00000;
					end else begin
						cnt <= cnt + 17'h00001;
					end
				end else if (cnt != 17'h00000) begin
					cnt <= cnt - 17'h00001;
				end
			end else begin
				if (!up_dir) begin
					cnt <= 17'h00000;
				end else if (cnt + 17'h00001 >= target) begin
					cnt <= 17'h00000;
				end else begin
					cnt <= cnt + 17'h00001;
				end
			end
		end
	end

	// debounced state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			deb <= 1'b0;
		end else if (smp_stb && !cfg_chg) begin
			if (code == 5'h00) begin
				deb <= smp_val;
			end else if (up_dir && cnt + 17'h00001 >= target) begin
				deb <= smp_val;
			end
		end
	end

	assign filtered = deb;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_bit <= 1'b0;
		end else begin
			status_bit <= filtered ^ comparator_invert;
		end
	end

	// pin a
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aux_pin_a_out <= 1'b0;
			aux_pin_a_oe  <= 1'b0;
		end else begin
			aux_pin_a_oe  <= (aux_pin_setup == `DIND_PIN_FUNC_DIN);
			aux_pin_a_out <= (aux_pin_setup == `DIND_PIN_FUNC_DIN) ?
				(filtered ^ comparator_invert) : 1'b0;
		end
	end

	sequence s_bypass_sample;
		smp_stb && code == 5'h00 && !cfg_chg;
	endsequence

	chk_bypass_pass: assert property (@(posedge clock) disable iff (!rst_n)
		s_bypass_sample |=> deb == $past(smp_val)) else $error("bypass not transparent");

	chk_mode1_clear: assert property (@(posedge clock) disable iff (!rst_n)
		smp_stb && mode1 && !up_dir && code != 5'h00 |=> cnt == 17'h00000)
		else $error("mode1 counter not cleared");

	chk_cfg_restart: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_chg |=> cnt == 17'h00000 && $stable(deb)) else $error("config change not restart");

	chk_mode0_down: assert property (@(posedge clock) disable iff (!rst_n)
		smp_stb && !mode1 && !up_dir && cnt != 17'h0 && !cfg_chg && code != 5'h0
		|=> cnt == $past(cnt) - 17'h00001) else $error("mode0 not counting down");

	chk_deb_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!smp_stb |=> $stable(deb)) else $error("debounce changed off strobe");

	chk_status_inv: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> status_bit == ($past(deb) ^ $past(comparator_invert)))
		else $error("status inversion wrong");

	chk_pin_gate: assert property (@(posedge clock) disable iff (!rst_n)
		aux_pin_setup != `DIND_PIN_FUNC_DIN |=> !aux_pin_a_oe && !aux_pin_a_out)
		else $error("pin driven while unselected");

	chk_source_sel: assert property (@(posedge clock) disable iff (!rst_n)
		smp_stb |-> smp_val == ($past(input_buffer_bypass) ? $past(comp_drive_terminal)
			: $past(comp_sense_low_terminal)))
		else $error("wrong comparator source");

	// sample at the new level that completes the interval
	sequence s_target_hit;
		smp_stb && code != 5'h00 && !cfg_chg && up_dir && cnt + 17'h00001 >= target;
	endsequence

	// sample at the new level short of the interval
	sequence s_step_up;
		smp_stb && code != 5'h00 && !cfg_chg && up_dir && cnt + 17'h00001 < target;
	endsequence

	chk_target_update: assert property (@(posedge clock) disable iff (!rst_n)
		s_target_hit |=> deb == $past(smp_val) && cnt == 17'h00000)
		else $error("target reached but output not updated");

	chk_count_up: assert property (@(posedge clock) disable iff (!rst_n)
		s_step_up |=> cnt == $past(cnt) + 17'h00001 && $stable(deb))
		else $error("new level sample not counted");

	chk_pin_drive: assert property (@(posedge clock) disable iff (!rst_n)
		aux_pin_setup == `DIND_PIN_FUNC_DIN
		|=> aux_pin_a_oe && aux_pin_a_out == ($past(deb) ^ $past(comparator_invert)))
		else $error("pin not driving debounced level");
endmodule // dind_top

// [testbench/dind_top_test.sv]
`include "dind_consts.svh"
module dind_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock    = 1'b0;
	logic        rst_n    = 1'b0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic        wb_we_i  = 1'b0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        lvl      = 1'b0;
	logic        split    = 1'b0;
	logic [31:0] wb_dat_o, q;
	logic        wb_ack_o, byp, refs, loop, pin, pin_oe, inv;
	int          num_errors = 0, comparisons = 0, seed = 32'h4f8ca6f0, r;
	// code 01: 13.0 us over the sample period, rounded to whole samples
	localparam int TGT_CODE1 = (13000 + `DIND_SAMPLE_NS / 2) / `DIND_SAMPLE_NS;

	dind_top uut (.clock(clock), .rst_n(rst_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .comp_sense_low_terminal(lvl ^ split),
		.comp_drive_terminal(lvl), .input_buffer_bypass(byp), .thresh_ref_supply(refs),
		.loop_adc_field_range(loop), .aux_pin_a_out(pin), .aux_pin_a_oe(pin_oe));

	initial begin
		forever #2 clock = ~clock;
	end

	task end_of_test;
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one classic cycle; entered right after a rising edge
	task automatic wb(input logic [31:0] a, d, input logic we, input logic [3:0] s,
		output logic [31:0] rq);
		int n;
		n = 0;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i  <= we;
		wb_sel_i <= s;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk("wb_ack", {31'h0, wb_ack_o}, 32'h1);
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] t;
		wb(a, d, 1'b1, 4'hf, t);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] rq);
		wb(a, 32'h0, 1'b0, 4'hf, rq);
	endtask

	task automatic smp(input int n);
		repeat (n * `DIND_SAMPLE_CYC) @(posedge clock);
	endtask

	function automatic logic exp_pass(input logic l, input logic iv);
		return l ^ iv;
	endfunction

	// level after up1 new, dn old, up2 new samples from a low output
	function automatic logic exp_level(input logic m, input int up1, dn, up2, tgt);
		int net;
		net = (up1 > dn) ? up1 - dn + up2 : up2;
		if (up1 >= tgt)
			return 1'b1;
		if (m)
			return up2 >= tgt;
		return net >= tgt;
	endfunction

	task automatic deb(input logic m);
		wr(`DIND_REG_FILTER, 32'h0);
		lvl <= 1'b0;
		smp(3);
		wr(`DIND_REG_FILTER, {26'h0, m, 5'h01});
		lvl <= 1'b1;
		smp(10);
		lvl <= 1'b0;
		smp(2);
		lvl <= 1'b1;
		smp(10);
		rd(`DIND_REG_STATUS, q);
		chk("deb_mid", q, {31'h0, exp_level(m, 10, 2, 10, TGT_CODE1)});
		smp(8);
		rd(`DIND_REG_STATUS, q);
		chk("deb_end", q, {31'h0, exp_level(m, 10, 2, 18, TGT_CODE1)});
		wr(`DIND_REG_FILTER, {26'h0, ~m, 5'h01});
		rd(`DIND_REG_STATUS, q);
		chk("deb_keep", q, 32'h1);
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		num_errors++;
		end_of_test;
	end

	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int a = 0; a < 16; a += 4) begin
			rd(a, q);
			chk("reset_reg", q, 32'h0);
		end
		chk("pin_oe_off", {31'h0, pin_oe}, 32'h0);
		rd(32'h10, q);
		chk("unmapped", q, 32'h0);
		r = $random(seed);
		wr(`DIND_REG_THRESH, {29'h0, r[2:0]});
		wb(`DIND_REG_THRESH, {29'h0, ~r[2:0]}, 1'b1, 4'he, q);
		rd(`DIND_REG_THRESH, q);
		chk("thr_reg", q, {29'h0, r[2:0]});
		chk("thr_out", {29'h0, loop, refs, byp}, {29'h0, r[2:0]});
		wr(`DIND_REG_THRESH, 32'h1);
		split <= 1'b1;
		lvl <= 1'b1;
		smp(3);
		rd(`DIND_REG_STATUS, q);
		chk("src_drive", q, 32'h1);
		wr(`DIND_REG_THRESH, 32'h0);
		smp(3);
		rd(`DIND_REG_STATUS, q);
		chk("src_sense", q, 32'h0);
		split <= 1'b0;
		wr(`DIND_REG_PIN, {29'h0, `DIND_PIN_FUNC_DIN});
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			lvl <= r[0];
			inv = r[1];
			wr(`DIND_REG_FILTER, {25'h0, inv, 6'h0});
			smp(3);
			rd(`DIND_REG_STATUS, q);
			chk("pass_stat", q, {31'h0, exp_pass(lvl, inv)});
			chk("pass_pin", {30'h0, pin_oe, pin}, {30'h1, exp_pass(lvl, inv)});
		end
		deb(1'b0);
		deb(1'b1);
		// reset in mid-run with every setting away from its reset value
		wr(`DIND_REG_FILTER, 32'h0000_007f);
		wr(`DIND_REG_THRESH, 32'h0000_0007);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		chk("rst_pin_oe", {31'h0, pin_oe}, 32'h0);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(`DIND_REG_FILTER, q);
		chk("rst_filter", q, 32'h0);
		rd(`DIND_REG_THRESH, q);
		chk("rst_thresh", q, 32'h0);
		rd(`DIND_REG_PIN, q);
		chk("rst_pin", q, 32'h0);
		end_of_test;
	end
endmodule // dind_top_test
